//--- logic/prfa_pkg.sv
/*
  package for the pointer register file: register offsets, widths, reset values and addressing modes.
  assumes a core that reaches the system registers through one 8-bit data-memory address space.
*/
package prfa_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_RAM_PTR_LOW = 8'h80;
  localparam logic [7:0] OFF_RAM_PTR_HIGH = 8'h81;
  localparam logic [7:0] OFF_TABLE_HIGH = 8'h82;
  localparam logic [7:0] OFF_ALT_PTR_LOW = 8'h83;
  localparam logic [7:0] OFF_ALT_PTR_HIGH = 8'h84;
  localparam logic [7:0] OFF_ROM_INDEX = 8'h85;
  localparam logic [7:0] OFF_WORK_LAST = 8'h87;
  localparam logic [7:0] GP_AREA_LAST = 8'h7f;
  localparam logic [7:0] ROM_INDEX_RST = 8'h00;
  localparam logic [7:0] UNDEF_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  typedef enum logic [1:0] {
    PRFA_MODE_DIRECT,
    PRFA_MODE_FIRST_IND,
    PRFA_MODE_SECOND_IND
  } prfa_mode_t;
  typedef enum logic {
    PRFA_TBL_ROM_INDEX,
    PRFA_TBL_ALT_PAIR
  } prfa_tblsel_t;
endpackage

//--- logic/prfa_byte_reg.sv
/*
  one 8-bit working register with two write ports: software store and table-read load.
  assumes both write strobes come from logic on mclk; the table load wins if both fire together.
*/
`timescale 1ns/10ps
`default_nettype none
module prfa_byte_reg
  import prfa_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // writes
  input wire logic sw_we,
  input wire logic [7:0] sw_data,
  input wire logic hw_we,
  input wire logic [7:0] hw_data,
  // state
  output logic [7:0] value
);
  logic [7:0] value_r;
  logic [7:0] value_nxt;

  assign value_nxt = hw_we ? hw_data : (sw_we ? sw_data : value_r);
  assign value = value_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      value_r <= RST_VAL;
    end else begin
      value_r <= value_nxt;
    end
  end
endmodule
`default_nettype wire

//--- logic/prfa_top.sv
/*
  pointer register file of an 8-bit core: working registers, indirect ram pointers, table-read
  pointer and table high byte, plus data-memory address forming for direct and indirect operands.
  assumes the execution core drives the register port and mode inputs from mclk logic and
  supplies the program-memory word for a table read in the same cycle as its strobe.
*/
// Notes on behaviour
// RULE1: ram_pointer_high and ram_pointer_low are 8-bit read/write working registers, reset undefined.
// RULE2: first indirect operand: bank from ram_pointer_high, location from ram_pointer_low.
// RULE3: second indirect operand: bank from alt_pointer_high, location from alt_pointer_low.
// RULE4: rom_index is 8-bit read/write, cleared at reset, table-read pointer or storage.
// RULE5: alt pointer pair is 8-bit read/write, undefined reset, working, ram and rom pointer.
// RULE6: table read puts word high byte into table_high_byte, low byte into accumulator.
// RULE7: table_high_byte is 8-bit read/write, undefined reset, otherwise general working storage.
// RULE8: software immediate stores target only working registers 0x80 through 0x87.
// RULE9: direct addressing moves data between accumulator and the encoded ram location.
// RULE10: bank 0 general-purpose area ends at 7FH and indirect pointers reach it.
// RULE11: a freshly written pointer is used by the very next dereference with no wait; tbl_rom_addr takes no bypass, only ram address forming does.
`timescale 1ns/10ps
`default_nettype none
module prfa_top
  import prfa_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // operand address forming
  input wire logic [1:0] oper_mode,
  input wire logic [7:0] oper_direct_addr,
  output logic [7:0] ram_bank,
  output logic [7:0] ram_loc,
  output logic ram_in_gp_area,
  // table read
  input wire logic tbl_sel,
  input wire logic tbl_load,
  input wire logic [15:0] tbl_word,
  output logic [15:0] tbl_rom_addr,
  output logic acc_load,
  output logic [7:0] acc_data,
  // immediate store guard
  output logic imm_target_ok
);
  logic [7:0] ptr_low;
  logic [7:0] ptr_high;
  logic [7:0] tbl_high;
  logic [7:0] alt_low;
  logic [7:0] alt_high;
  logic [7:0] rom_idx;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic acc_load_r;
  logic [7:0] acc_data_r;
  logic [7:0] bank_r;
  logic [7:0] loc_r;
  logic [7:0] bank_nxt;
  logic [7:0] loc_nxt;
  logic we_ptr_low;
  logic we_ptr_high;
  logic we_tbl_high;
  logic we_alt_low;
  logic we_alt_high;
  logic we_rom_idx;
  logic [7:0] fwd_ptr_low;
  logic [7:0] fwd_ptr_high;
  logic [7:0] fwd_alt_low;
  logic [7:0] fwd_alt_high;
  prfa_mode_t mode;

  assign mode = prfa_mode_t'(oper_mode);

  // write decode
  assign we_ptr_low = reg_wr && (reg_addr == OFF_RAM_PTR_LOW); // RULE1
  assign we_ptr_high = reg_wr && (reg_addr == OFF_RAM_PTR_HIGH); // RULE1
  assign we_tbl_high = reg_wr && (reg_addr == OFF_TABLE_HIGH); // RULE7
  assign we_alt_low = reg_wr && (reg_addr == OFF_ALT_PTR_LOW); // RULE5
  assign we_alt_high = reg_wr && (reg_addr == OFF_ALT_PTR_HIGH); // RULE5
  assign we_rom_idx = reg_wr && (reg_addr == OFF_ROM_INDEX); // RULE4

  // undefined-reset registers still start from a known value to keep simulation clean
  prfa_byte_reg #(.RST_VAL(UNDEF_RST)) u_ptr_low (
    .mclk(mclk), .reset_n(reset_n), .sw_we(we_ptr_low), .sw_data(reg_wdata),
    .hw_we(1'b0), .hw_data(UNDEF_RST), .value(ptr_low)
  );
  prfa_byte_reg #(.RST_VAL(UNDEF_RST)) u_ptr_high (
    .mclk(mclk), .reset_n(reset_n), .sw_we(we_ptr_high), .sw_data(reg_wdata),
    .hw_we(1'b0), .hw_data(UNDEF_RST), .value(ptr_high)
  );
  prfa_byte_reg #(.RST_VAL(UNDEF_RST)) u_tbl_high (
    .mclk(mclk), .reset_n(reset_n), .sw_we(we_tbl_high), .sw_data(reg_wdata),
    .hw_we(tbl_load), .hw_data(tbl_word[15:8]), .value(tbl_high)
  ); // RULE6
  prfa_byte_reg #(.RST_VAL(UNDEF_RST)) u_alt_low (
    .mclk(mclk), .reset_n(reset_n), .sw_we(we_alt_low), .sw_data(reg_wdata),
    .hw_we(1'b0), .hw_data(UNDEF_RST), .value(alt_low)
  );
  prfa_byte_reg #(.RST_VAL(UNDEF_RST)) u_alt_high (
    .mclk(mclk), .reset_n(reset_n), .sw_we(we_alt_high), .sw_data(reg_wdata),
    .hw_we(1'b0), .hw_data(UNDEF_RST), .value(alt_high)
  );
  prfa_byte_reg #(.RST_VAL(ROM_INDEX_RST)) u_rom_idx (
    .mclk(mclk), .reset_n(reset_n), .sw_we(we_rom_idx), .sw_data(reg_wdata),
    .hw_we(1'b0), .hw_data(ROM_INDEX_RST), .value(rom_idx)
  ); // RULE4

  // read mux; unmapped addresses read as zero
  always_comb begin
    if (reg_addr == OFF_RAM_PTR_LOW) begin
      rdata_nxt = ptr_low;
    end else if (reg_addr == OFF_RAM_PTR_HIGH) begin
      rdata_nxt = ptr_high;
    end else if (reg_addr == OFF_TABLE_HIGH) begin
      rdata_nxt = tbl_high;
    end else if (reg_addr == OFF_ALT_PTR_LOW) begin
      rdata_nxt = alt_low;
    end else if (reg_addr == OFF_ALT_PTR_HIGH) begin
      rdata_nxt = alt_high;
    end else if (reg_addr == OFF_ROM_INDEX) begin
      rdata_nxt = rom_idx;
    end else begin
      rdata_nxt = UNMAPPED_READ;
    end
  end

  // bypass a same-cycle pointer write so the dereference never waits a cycle
  assign fwd_ptr_low = we_ptr_low ? reg_wdata : ptr_low; // RULE11
  assign fwd_ptr_high = we_ptr_high ? reg_wdata : ptr_high; // RULE11
  assign fwd_alt_low = we_alt_low ? reg_wdata : alt_low; // RULE11
  assign fwd_alt_high = we_alt_high ? reg_wdata : alt_high; // RULE11

  // address forming; direct addresses sit in bank 0
  always_comb begin
    case (mode)
      PRFA_MODE_FIRST_IND: begin
        bank_nxt = fwd_ptr_high; // RULE2
        loc_nxt = fwd_ptr_low; // RULE2
      end
      PRFA_MODE_SECOND_IND: begin
        bank_nxt = fwd_alt_high; // RULE3
        loc_nxt = fwd_alt_low; // RULE3
      end
      default: begin
        bank_nxt = 8'h00; // RULE9
        loc_nxt = oper_direct_addr; // RULE9
      end
    endcase
  end

  assign ram_bank = bank_r;
  assign ram_loc = loc_r;
  assign ram_in_gp_area = (bank_r == 8'h00) && (loc_r <= GP_AREA_LAST); // RULE10

  // table pointer: rom_index alone, or the alt pair as a 16-bit address
  assign tbl_rom_addr = (tbl_sel == PRFA_TBL_ALT_PAIR) ? {alt_high, alt_low} : {8'h00, rom_idx};

  // immediate stores are legal only into the working register window
  assign imm_target_ok = (reg_addr >= OFF_RAM_PTR_LOW) && (reg_addr <= OFF_WORK_LAST); // RULE8

  assign reg_rdata = rdata_r;
  assign acc_load = acc_load_r;
  assign acc_data = acc_data_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= UNMAPPED_READ;
      bank_r <= 8'h00;
      loc_r <= 8'h00;
      acc_load_r <= 1'b0;
      acc_data_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : UNMAPPED_READ;
      bank_r <= bank_nxt;
      loc_r <= loc_nxt;
      acc_load_r <= tbl_load; // RULE6
      acc_data_r <= tbl_load ? tbl_word[7:0] : acc_data_r; // RULE6
    end
  end

  AST_FIRST_IND: assert property (@(posedge mclk) disable iff (!reset_n) // RULE2
    (mode == PRFA_MODE_FIRST_IND) |=> (ram_bank == $past(fwd_ptr_high) && ram_loc == $past(fwd_ptr_low)))
    else $error("first pointer address wrong");
  AST_SECOND_IND: assert property (@(posedge mclk) disable iff (!reset_n) // RULE3
    (mode == PRFA_MODE_SECOND_IND) |=> (ram_bank == $past(fwd_alt_high) && ram_loc == $past(fwd_alt_low)))
    else $error("second pointer address wrong");
  AST_DIRECT: assert property (@(posedge mclk) disable iff (!reset_n) // RULE9
    (mode == PRFA_MODE_DIRECT) |=> (ram_bank == 8'h00 && ram_loc == $past(oper_direct_addr)))
    else $error("direct address wrong");
  sequence s_write_ptr_low;
    reg_wr && reg_addr == OFF_RAM_PTR_LOW && mode == PRFA_MODE_FIRST_IND;
  endsequence
  AST_PTR_BYPASS: assert property (@(posedge mclk) disable iff (!reset_n) // RULE11
    s_write_ptr_low |=> (ram_loc == $past(reg_wdata)))
    else $error("pointer write not used at once");
  AST_TBL_HIGH: assert property (@(posedge mclk) disable iff (!reset_n) // RULE6
    tbl_load |=> (reg_rd && reg_addr == OFF_TABLE_HIGH) ##0 1'b1 ##1 (reg_rdata == $past(tbl_word[15:8], 2))
    or !(reg_rd && reg_addr == OFF_TABLE_HIGH))
    else $error("table high byte lost");
  AST_ACC_LOW: assert property (@(posedge mclk) disable iff (!reset_n) // RULE6
    tbl_load |=> (acc_load && acc_data == $past(tbl_word[7:0])))
    else $error("accumulator low byte wrong");
  AST_ROM_RESET: assert property (@(posedge mclk) // RULE4
    $rose(reset_n) |-> (rom_idx == 8'h00))
    else $error("rom index not cleared");
  AST_RW_LOOP: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
    (reg_wr && reg_addr == OFF_ALT_PTR_HIGH && !tbl_load) ##1 (reg_rd && reg_addr == OFF_ALT_PTR_HIGH && !reg_wr)
    |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("alt pointer read back wrong");
  AST_WORK_RW: assert property (@(posedge mclk) disable iff (!reset_n) // RULE1
    (reg_wr && reg_addr == OFF_RAM_PTR_HIGH) |=> (ptr_high == $past(reg_wdata)))
    else $error("ram pointer high not stored");
  AST_TBL_WORK: assert property (@(posedge mclk) disable iff (!reset_n) // RULE7
    (reg_wr && reg_addr == OFF_TABLE_HIGH && !tbl_load) |=> (tbl_high == $past(reg_wdata)))
    else $error("table high byte not writable");
  AST_GP_AREA: assert property (@(posedge mclk) disable iff (!reset_n) // RULE10
    (ram_bank == 8'h00 && ram_loc == 8'h80) |-> !ram_in_gp_area)
    else $error("gp area reaches past 7f");
  AST_IMM: assert property (@(posedge mclk) disable iff (!reset_n) // RULE8
    (reg_addr == 8'h88 || reg_addr == 8'h7f) |-> !imm_target_ok)
    else $error("immediate window wrong");

  // a stray strobe must never disturb a pointer between instructions
  sequence s_ptr_low_quiet;
    !we_ptr_low;
  endsequence
  sequence s_ptr_high_quiet;
    !we_ptr_high;
  endsequence
  sequence s_alt_low_quiet;
    !we_alt_low;
  endsequence
  sequence s_alt_high_quiet;
    !we_alt_high;
  endsequence
  sequence s_rom_quiet;
    !we_rom_idx;
  endsequence
  sequence s_tbl_quiet;
    !we_tbl_high && !tbl_load;
  endsequence

  // holds
  AST_PTR_LOW_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // RULE1
    s_ptr_low_quiet |=> $stable(ptr_low))
    else $error("ram pointer low changed unwritten");
  AST_PTR_HIGH_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // RULE1
    s_ptr_high_quiet |=> $stable(ptr_high))
    else $error("ram pointer high changed unwritten");
  AST_ALT_LOW_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
    s_alt_low_quiet |=> $stable(alt_low))
    else $error("alt pointer low changed unwritten");
  AST_ALT_HIGH_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
    s_alt_high_quiet |=> $stable(alt_high))
    else $error("alt pointer high changed unwritten");
  AST_ROM_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // RULE4
    s_rom_quiet |=> $stable(rom_idx))
    else $error("rom index changed unwritten");
  AST_TBL_HOLD: assert property (@(posedge mclk) disable iff (!reset_n) // RULE7
    s_tbl_quiet |=> $stable(tbl_high))
    else $error("table high byte changed unwritten");

  // software stores
  AST_PTR_LOW_WR: assert property (@(posedge mclk) disable iff (!reset_n) // RULE1
    we_ptr_low |=> (ptr_low == $past(reg_wdata)))
    else $error("ram pointer low not stored");
  AST_ALT_LOW_WR: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
    we_alt_low |=> (alt_low == $past(reg_wdata)))
    else $error("alt pointer low not stored");
  AST_ALT_HIGH_WR: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
    we_alt_high |=> (alt_high == $past(reg_wdata)))
    else $error("alt pointer high not stored");
  AST_ROM_WR: assert property (@(posedge mclk) disable iff (!reset_n) // RULE4
    we_rom_idx |=> (rom_idx == $past(reg_wdata)))
    else $error("rom index not stored");

  // the second pointer bypasses a same-cycle store just like the first
  sequence s_write_alt_low;
    reg_wr && reg_addr == OFF_ALT_PTR_LOW && mode == PRFA_MODE_SECOND_IND;
  endsequence
  AST_ALT_BYPASS: assert property (@(posedge mclk) disable iff (!reset_n) // RULE11
    s_write_alt_low |=> (ram_loc == $past(reg_wdata)))
    else $error("alt pointer write not used at once");

  // store then load back with no gap between the strobes
  AST_RW_PTR_LOW: assert property (@(posedge mclk) disable iff (!reset_n) // RULE1
    we_ptr_low ##1 (reg_rd && reg_addr == OFF_RAM_PTR_LOW && !reg_wr)
    |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("ram pointer low read back wrong");
  AST_RW_PTR_HIGH: assert property (@(posedge mclk) disable iff (!reset_n) // RULE1
    we_ptr_high ##1 (reg_rd && reg_addr == OFF_RAM_PTR_HIGH && !reg_wr)
    |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("ram pointer high read back wrong");
  AST_RW_TBL: assert property (@(posedge mclk) disable iff (!reset_n) // RULE7
    (we_tbl_high && !tbl_load) ##1 (reg_rd && reg_addr == OFF_TABLE_HIGH && !reg_wr && !tbl_load)
    |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("table high byte read back wrong");
  AST_RW_ALT_LOW: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
    we_alt_low ##1 (reg_rd && reg_addr == OFF_ALT_PTR_LOW && !reg_wr)
    |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("alt pointer low read back wrong");
  AST_RW_ROM: assert property (@(posedge mclk) disable iff (!reset_n) // RULE4
    we_rom_idx ##1 (reg_rd && reg_addr == OFF_ROM_INDEX && !reg_wr)
    |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("rom index read back wrong");

  // table read and read port timing
  AST_TBL_LOAD_WINS: assert property (@(posedge mclk) disable iff (!reset_n) // RULE6
    tbl_load |=> (tbl_high == $past(tbl_word[15:8])))
    else $error("table load lost to software store");
  AST_ACC_PULSE: assert property (@(posedge mclk) disable iff (!reset_n) // RULE6
    !tbl_load |=> (!acc_load && acc_data == $past(acc_data)))
    else $error("accumulator moved without a table read");
  AST_TBL_ADDR_X: assert property (@(posedge mclk) disable iff (!reset_n) // RULE4
    (tbl_sel == PRFA_TBL_ROM_INDEX) |-> (tbl_rom_addr == {8'h00, rom_idx}))
    else $error("table address from rom index wrong");
  AST_TBL_ADDR_YZ: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
    (tbl_sel == PRFA_TBL_ALT_PAIR) |-> (tbl_rom_addr == {alt_high, alt_low}))
    else $error("table address from alt pair wrong");
  AST_RD_IDLE: assert property (@(posedge mclk) disable iff (!reset_n) // RULE1
    !reg_rd |=> (reg_rdata == UNMAPPED_READ))
    else $error("read data stands too long");

  // window edges and the spare mode
  AST_GP_IN: assert property (@(posedge mclk) disable iff (!reset_n) // RULE10
    (ram_bank == 8'h00 && ram_loc == GP_AREA_LAST) |-> ram_in_gp_area)
    else $error("gp area misses its last location");
  AST_GP_BANK: assert property (@(posedge mclk) disable iff (!reset_n) // RULE10
    (ram_bank != 8'h00) |-> !ram_in_gp_area)
    else $error("gp area claimed outside bank 0");
  AST_DIRECT_ALIAS: assert property (@(posedge mclk) disable iff (!reset_n) // RULE9
    (oper_mode == 2'd3) |=> (ram_bank == 8'h00 && ram_loc == $past(oper_direct_addr)))
    else $error("spare mode not treated as direct");
  AST_IMM_IN: assert property (@(posedge mclk) disable iff (!reset_n) // RULE8
    (reg_addr == OFF_RAM_PTR_LOW || reg_addr == OFF_WORK_LAST) |-> imm_target_ok)
    else $error("immediate window misses an end");
endmodule
`default_nettype wire

//--- test/prfa_rom_model.sv
/*
  program-memory model standing in for the core side of a table read.
  assumes the word is wanted in the same cycle as the address, so it answers combinationally.
*/
`timescale 1ns/10ps
`default_nettype none
module prfa_rom_model (
  // fetch
  input wire logic [15:0] rom_addr,
  output logic [15:0] rom_word
);
  // both address bytes feed the word, so a lost pointer byte shows up in the fetched data
  assign rom_word = {rom_addr[7:0] ^ 8'h5a, rom_addr[15:8] ^ rom_addr[7:0] ^ 8'hc3};
endmodule
`default_nettype wire

//--- test/testbench.sv
/*
  self-checking bench for the pointer register file, one task per scenario.
  assumes prfa_top and the rom model are compiled first; single 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module testbench;
  import prfa_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] oper_mode = 2'd0;
  logic [7:0] oper_direct_addr = 8'h00;
  logic [7:0] ram_bank;
  logic [7:0] ram_loc;
  logic ram_in_gp_area;
  logic tbl_sel = 1'b0;
  logic tbl_load = 1'b0;
  logic [15:0] tbl_word;
  logic [15:0] tbl_rom_addr;
  logic acc_load;
  logic [7:0] acc_data;
  logic imm_target_ok;
  int n_errors = 0;
  int cmp_count = 0;
  prfa_top DUT (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .oper_mode(oper_mode),
    .oper_direct_addr(oper_direct_addr), .ram_bank(ram_bank), .ram_loc(ram_loc),
    .ram_in_gp_area(ram_in_gp_area), .tbl_sel(tbl_sel), .tbl_load(tbl_load), .tbl_word(tbl_word),
    .tbl_rom_addr(tbl_rom_addr), .acc_load(acc_load), .acc_data(acc_data),
    .imm_target_ok(imm_target_ok));
  prfa_rom_model rom (.rom_addr(tbl_rom_addr), .rom_word(tbl_word));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stand for one cycle only, so the idle zero afterwards is checked too
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", ex, reg_rdata)
    @(posedge mclk);
    #1;
    `CHK("reg_rdata idle", UNMAPPED_READ, reg_rdata)
  endtask
  task automatic form(input logic [1:0] m, input logic [7:0] da, input logic [7:0] eb,
                      input logic [7:0] el, input logic eg);
    @(posedge mclk);
    oper_mode <= m;
    oper_direct_addr <= da;
    @(posedge mclk);
    #1;
    `CHK("ram_bank", eb, ram_bank)
    `CHK("ram_loc", el, ram_loc)
    `CHK("ram_in_gp_area", eg, ram_in_gp_area)
  endtask
  task automatic test_regs();
    rd(OFF_ROM_INDEX, ROM_INDEX_RST);
    for (int i = 0; i < 6; i++) begin
      wr(OFF_RAM_PTR_LOW + 8'(i), 8'ha5 ^ 8'(i * 17));
    end
    wr(8'h90, 8'hff);
    for (int i = 0; i < 6; i++) begin
      rd(OFF_RAM_PTR_LOW + 8'(i), 8'ha5 ^ 8'(i * 17));
    end
    rd(8'h90, UNMAPPED_READ);
    rd(8'h86, UNMAPPED_READ);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      reg_addr <= OFF_RAM_PTR_LOW + 8'(i);
      reg_wdata <= 8'h3c + 8'(i);
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata b2b", 8'h3c + 8'(i), reg_rdata)
    end
    $display("test regs done");
  endtask
  task automatic test_ptr();
    wr(OFF_RAM_PTR_LOW, 8'h20);
    wr(OFF_RAM_PTR_HIGH, 8'h03);
    wr(OFF_ALT_PTR_LOW, GP_AREA_LAST);
    wr(OFF_ALT_PTR_HIGH, 8'h00);
    form(2'd1, 8'h55, 8'h03, 8'h20, 1'b0);
    form(2'd2, 8'h55, 8'h00, 8'h7f, 1'b1);
    form(2'd0, 8'h80, 8'h00, 8'h80, 1'b0);
    form(2'd3, 8'h12, 8'h00, 8'h12, 1'b1);
    @(posedge mclk);
    reg_addr <= OFF_ALT_PTR_LOW;
    reg_wdata <= 8'h44;
    reg_wr <= 1'b1;
    oper_mode <= 2'd2;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
    `CHK("ram_loc fresh", 8'h44, ram_loc)
    @(posedge mclk);
    reg_addr <= OFF_RAM_PTR_LOW;
    reg_wdata <= 8'h31;
    reg_wr <= 1'b1;
    oper_mode <= 2'd1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
    `CHK("ram_loc fresh hl", 8'h31, ram_loc)
    `CHK("ram_bank fresh hl", 8'h03, ram_bank)
    $display("test ptr done");
  endtask
  // second load collides with a software store of the high-byte register; the load must win
  task automatic test_tbl();
    wr(OFF_ALT_PTR_HIGH, 8'h12);
    wr(OFF_ROM_INDEX, 8'h37);
    #1;
    `CHK("tbl_rom_addr x", 16'h0037, tbl_rom_addr)
    @(posedge mclk);
    tbl_sel <= 1'b0;
    tbl_load <= 1'b1;
    @(posedge mclk);
    tbl_sel <= 1'b1;
    reg_addr <= OFF_TABLE_HIGH;
    reg_wdata <= 8'hee;
    reg_wr <= 1'b1;
    #1;
    `CHK("acc_load", 1'b1, acc_load)
    `CHK("acc_data", 8'hf4, acc_data)
    `CHK("tbl_rom_addr yz", 16'h1244, tbl_rom_addr)
    @(posedge mclk);
    tbl_load <= 1'b0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    #1;
    `CHK("acc_data 2", 8'h95, acc_data)
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata after load", 8'h1e, reg_rdata)
    `CHK("acc_load end", 1'b0, acc_load)
    `CHK("acc_data hold", 8'h95, acc_data)
    rd(OFF_TABLE_HIGH, 8'h1e);
    $display("test tbl done");
  endtask
  task automatic test_imm();
    logic [7:0] a;
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : (i == 2) ? OFF_WORK_LAST : 8'h88;
      @(posedge mclk);
      reg_addr <= a;
      #1;
      `CHK("imm_target_ok", (a >= 8'h80 && a <= 8'h87), imm_target_ok)
    end
    $display("test imm done");
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    test_regs();
    test_ptr();
    test_tbl();
    test_imm();
    end_sim();
  end
endmodule
`default_nettype wire
